//--- tb/adc_power_mode_serial_control_checker.sv
// concurrent checks on the ports of the converter control block
// assumes one ref_clk domain; bound to every instance of the block
module adc_power_mode_serial_control_checker
  import adc_ctrl_pkg::*;
#(
  parameter int RESULT_W = adc_ctrl_pkg::RESULT_BITS,
  parameter int DEPTH = adc_ctrl_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // serial pins
  input wire logic chipSelectActiveLow,
  input wire logic serialDataOut,
  input wire logic serialDataOutOe,
  input wire logic conversionStrobeOut,
  input wire logic conversionStrobeOutOe,
  // result port and analog control
  input wire logic resultReady,
  input wire adc_ctrl_pkg::ctrl_byte_t controlByte,
  input wire adc_ctrl_pkg::power_state_t powerState,
  input wire logic [1:0] powerModeSetting,
  input wire logic conversionActive,
  input wire logic readyToConvert
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  logic seenActive_q; // a conversion has been started since reset
  logic [5:0] upCount_q; // cycles since reset, saturating
  // helper state kept apart from the assertions
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      seenActive_q <= 1'b0;
      upCount_q <= 6'h00;
    end else begin
      seenActive_q <= seenActive_q | conversionActive;
      upCount_q <= (upCount_q == 6'h3f) ? upCount_q : upCount_q + 6'h01;
    end
  end
  oe_off_a: assert property (
    chipSelectActiveLow [*5] |-> !serialDataOutOe && !conversionStrobeOutOe)
    else $error("pins driven while deselected");
  active_power_a: assert property (
    conversionActive [*3] |-> powerState == PWR_NORMAL)
    else $error("not fully powered during conversion");
  mode_decode_a: assert property (
    !conversionActive [*3] |-> powerState == (powerModeSetting == 2'h3 ? PWR_NORMAL :
    powerModeSetting == 2'h0 ? PWR_FULL_DOWN : PWR_REDUCED))
    else $error("power state does not match mode bits");
  setting_hold_a: assert property (
    $changed(powerModeSetting) |-> $rose(conversionActive))
    else $error("mode bits changed without a new control byte");
  mode_field_a: assert property (
    conversionActive |->
    powerModeSetting == {controlByte.powerModeBitHigh, controlByte.powerModeBitLow})
    else $error("mode bits not taken from the two low bits");
  strobe_width_a: assert property (
    $rose(conversionStrobeOut) |-> conversionStrobeOut [*8] ##1 !conversionStrobeOut)
    else $error("strobe not one serial period wide");
  // strobe lands two serial periods after the last control bit; assumes eight-cycle periods
  strobe_place_a: assert property (
    $rose(conversionStrobeOut) |-> $past(conversionActive, 16) && !$past(conversionActive, 17))
    else $error("strobe not two serial periods after the control byte");
  strobe_active_a: assert property (
    conversionStrobeOut |-> conversionActive && conversionStrobeOutOe)
    else $error("strobe outside a conversion");
  data_zero_a: assert property (
    !seenActive_q && !conversionActive |-> !serialDataOut)
    else $error("data output not zero before first conversion");
  ready_early_a: assert property (
    upCount_q < 6'h27 |-> !readyToConvert)
    else $error("ready flag too early");
  ready_late_a: assert property (
    upCount_q > 6'h29 |-> readyToConvert)
    else $error("ready flag too late");
  // main scenarios reached
  cover property ($rose(conversionStrobeOut));
  cover property (powerState == PWR_FULL_DOWN);
  cover property (powerState == PWR_REDUCED);
  cover property ($fell(resultReady));
endmodule // adc_power_mode_serial_control_checker
bind adc_power_mode_serial_control adc_power_mode_serial_control_checker #(
  .RESULT_W(RESULT_W), .DEPTH(DEPTH)) chk (.ref_clk, .nrst, .chipSelectActiveLow,
  .serialDataOut, .serialDataOutOe, .conversionStrobeOut, .conversionStrobeOutOe,
  .resultReady, .controlByte, .powerState, .powerModeSetting, .conversionActive,
  .readyToConvert);

//--- tb/spi_host_model.sv
// host side of the serial link: select, clock idle low, data out msb first
// assumes the bench clock refClk; every pin change lands 1 ns after its edge
module spi_host_model (
  // bench clock
  input wire logic refClk,
  // pins from the device
  input wire logic dataOut,
  input wire logic dataOutOe,
  // pins to the device
  output logic selN,
  output logic sclk,
  output logic din
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lastBit = 1'b0; // last level seen on the data pin
  logic pinLevel; // resolved data pin level
  // a released pin shows the inverse of its last value, never a stale copy
  assign pinLevel = dataOutOe ? dataOut : ~lastBit;
  // idle: deselected, clock standing low between frames
  initial begin
    selN = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // four ref cycles per half: 1.25 MHz
  task automatic halfPeriod();
    repeat (4) @(posedge refClk);
    #1;
  endtask
  task automatic frame(input logic [7:0] ctrl, input int nBits, output logic [23:0] rx);
    rx = '0;
    selN = 1'b0;
    halfPeriod();
    for (int i = 0; i < nBits; i++) begin
      din = (i < 8) ? ctrl[7-i] : 1'b0;
      halfPeriod();
      sclk = 1'b1;
      rx = {rx[22:0], pinLevel};
      lastBit = pinLevel;
      halfPeriod();
      sclk = 1'b0;
    end
    din = 1'b0;
    halfPeriod();
    selN = 1'b1;
    halfPeriod();
    halfPeriod();
  endtask
endmodule // spi_host_model

//--- tb/tb_adc_power_mode_serial_control.sv
// self-checking bench of the converter control block with a serial host model
// assumes a 10 MHz ref_clk and a 1.25 MHz serial clock from the host
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_total++; \
  $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); end end
module tb_adc_power_mode_serial_control;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_ctrl_pkg::*;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [9:0] res;
    power_state_t st;
  } row_t;
  logic ref_clk, nrst, selN, sclk, din, dOut, dOutOe, stb, stbOe;
  logic resultValid, resultReady, conversionActive, readyToConvert, ok;
  logic [9:0] resultData;
  logic [1:0] powerModeSetting;
  logic [23:0] rx;
  ctrl_byte_t controlByte;
  power_state_t powerState;
  int err_total = 0;
  int checks = 0;
  int n;
  // ordinary cases: control byte, offered result, state after the conversion
  row_t rows [6] = '{'{8'h83, 10'h3ff, PWR_NORMAL}, '{8'hf1, 10'h2aa, PWR_REDUCED},
    '{8'ha2, 10'h155, PWR_REDUCED}, '{8'hc0, 10'h001, PWR_FULL_DOWN},
    '{8'h9f, 10'h200, PWR_NORMAL}, '{8'hb3, 10'h3fe, PWR_NORMAL}};
  adc_power_mode_serial_control dut (.ref_clk(ref_clk), .nrst(nrst),
    .chipSelectActiveLow(selN), .serialClock(sclk), .serialDataIn(din),
    .serialDataOut(dOut), .serialDataOutOe(dOutOe), .conversionStrobeOut(stb),
    .conversionStrobeOutOe(stbOe), .resultValid(resultValid), .resultData(resultData),
    .resultReady(resultReady), .controlByte(controlByte), .powerState(powerState),
    .powerModeSetting(powerModeSetting), .conversionActive(conversionActive),
    .readyToConvert(readyToConvert));
  spi_host_model host (.refClk(ref_clk), .dataOut(dOut), .dataOutOe(dOutOe),
    .selN(selN), .sclk(sclk), .din(din));
  // bench clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // verdict and end of run, shared with the watchdog
  task automatic end_of_test();
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // offers one result word for a cycle; valid stays up for back-to-back offers
  task automatic offer(input logic [9:0] v, output logic accepted);
    resultValid = 1'b1;
    resultData = v;
    @(negedge ref_clk) accepted = resultReady;
    @(posedge ref_clk) #1;
  endtask
  // one full conversion and the state it leaves behind
  task automatic convert(input logic [7:0] c, input logic [9:0] res, input power_state_t st);
    host.frame(c, 24, rx);
    `CHK(rx, {8'h00, 3'h0, res, 3'h0})
    `CHK(powerState, st)
    `CHK(powerModeSetting, c[1:0])
    `CHK(controlByte, c)
    `CHK(dOutOe, 1'b0)
  endtask
  // hang guard, well beyond the expected run of about 18000 cycles
  initial begin
    #3_000_000;
    err_total++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    resultValid = 1'b0;
    resultData = 10'h000;
    repeat (10) @(posedge ref_clk);
    #1 nrst = 1'b1;
    @(posedge ref_clk) #1;
    `CHK(powerState, PWR_NORMAL)
    `CHK(powerModeSetting, 2'h3)
    `CHK(readyToConvert, 1'b0)
    repeat (101) @(posedge ref_clk);
    #1;
    `CHK(readyToConvert, 1'b1)
    foreach (rows[i]) begin
      if (i > 0 && rows[i-1].st == PWR_FULL_DOWN) host.frame(rows[i].ctrl, 24, rx);
      offer(rows[i].res, ok);
      resultValid = 1'b0;
      convert(rows[i].ctrl, rows[i].res, rows[i].st);
    end
    // abort in mid-result: stored mode still applied
    host.frame(8'h80, 14, rx);
    `CHK(conversionActive, 1'b0)
    `CHK(powerState, PWR_FULL_DOWN)
    // fill the result buffer until it refuses
    n = 0;
    for (int i = 0; i < 12; i++) begin
      offer(10'(10'h100 + n), ok);
      if (ok) n++;
    end
    resultValid = 1'b0;
    `CHK(n, 8)
    `CHK(resultReady, 1'b0)
    // host lets the reference settle 1.4 ms before full accuracy
    repeat (14000) @(posedge ref_clk);
    #1;
    `CHK(powerState, PWR_FULL_DOWN)
    // drain back to back, then empty
    for (int k = 0; k < 9; k++) convert(8'h81, (k < 8) ? 10'(10'h100 + k) : 10'h000, PWR_REDUCED);
    `CHK(resultReady, 1'b1)
    end_of_test();
  end
endmodule // tb_adc_power_mode_serial_control

//--- verilog/adc_ctrl_pkg.sv
// constants, control-byte layout and power states of the converter control logic
// assumes a 10 MHz ref_clk and a serial clock far slower than it (sampled, not a clock)
package adc_ctrl_pkg;

  // result and control byte widths
  localparam int RESULT_BITS = 10;
  localparam int CTRL_BITS = 8;

  // control byte, start bit first
  typedef struct packed {
    logic start;
    logic [2:0] channelSelect;
    logic inputRange;
    logic inputMode;
    logic powerModeBitHigh;
    logic powerModeBitLow;
  } ctrl_byte_t;

  // power mode codes as carried in the control byte
  localparam logic [1:0] PM_FULL_POWER_DOWN = 2'h0;
  localparam logic [1:0] PM_NORMAL = 2'h3;
  localparam logic [1:0] PM_RESET = PM_NORMAL;

  // power state applied to the analog circuits
  typedef enum logic [1:0] {
    PWR_FULL_DOWN,
    PWR_REDUCED,
    PWR_NORMAL
  } power_state_t;

  // serial clock edge numbers, counted from the first edge after the control byte
  localparam logic [4:0] STROBE_EDGE = 5'h02;
  localparam logic [4:0] FIRST_SHIFT_EDGE = 5'h03;
  localparam logic [4:0] LAST_SHIFT_EDGE = 5'h0c;

  // timing: reset to ready with external reference
  localparam int CLK_PERIOD_NS = 100;
  localparam int READY_TIME_NS = 4000;
  localparam int READY_CYCLES = (READY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // result fifo depth
  localparam int FIFO_DEPTH = 8;

endpackage

//--- verilog/adc_power_mode_serial_control.sv
// serial control port and power sequencing of a 10-bit sar converter
// assumes sclk, select and data-in pins are asynchronous to ref_clk and
// that sclk runs well below a quarter of ref_clk so every edge is seen
module adc_power_mode_serial_control
  import adc_ctrl_pkg::*;
#(
  parameter int RESULT_W = adc_ctrl_pkg::RESULT_BITS,
  parameter int DEPTH = adc_ctrl_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // serial pins from the host
  input wire logic chipSelectActiveLow,
  input wire logic serialClock,
  input wire logic serialDataIn,
  // serial pins to the host, with output enables
  output logic serialDataOut,
  output logic serialDataOutOe,
  output logic conversionStrobeOut,
  output logic conversionStrobeOutOe,
  // results from the sar core
  input wire logic resultValid,
  input wire logic [RESULT_W-1:0] resultData,
  output logic resultReady,
  // control to the analog side
  output adc_ctrl_pkg::ctrl_byte_t controlByte,
  output adc_ctrl_pkg::power_state_t powerState,
  output logic [1:0] powerModeSetting,
  output logic conversionActive,
  output logic readyToConvert
);
  import adc_ctrl_pkg::*;

  // sequencer states
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_RECEIVE,
    SEQ_WAIT,
    SEQ_SHIFT
  } seq_state_t;

  // two-stage synchronisers; stage one is read only by stage two
  logic [1:0] csMeta_q;
  logic [1:0] sclkMeta_q;
  logic [1:0] dinMeta_q;
  logic sclkPrev_q;  // last synchronised sclk, for edge finding
  logic csLowSync;
  logic dinSync;
  logic sclkRise;

  seq_state_t state_q;  // sequencer state
  logic [2:0] bitCnt_q;  // control bits received after the start bit
  logic [CTRL_BITS-2:0] rxShift_q;  // incoming control bits
  logic [4:0] edgeCnt_q;  // sclk rises since the control byte ended
  logic [RESULT_W-1:0] txShift_q;  // result bits still to shift out
  localparam int READY_W = $clog2(READY_CYCLES + 1);  // width of the ready counter
  logic [READY_W-1:0] readyCnt_q;  // time since reset
  logic popResult;
  logic fifoValid;
  logic [RESULT_W-1:0] fifoData;
  ctrl_byte_t newByte;

  // decode of the two mode bits into a power state
  function automatic power_state_t decodeMode(input logic [1:0] code);
    case (code)
      PM_FULL_POWER_DOWN: decodeMode = PWR_FULL_DOWN;
      PM_NORMAL: decodeMode = PWR_NORMAL;
      default: decodeMode = PWR_REDUCED;
    endcase
  endfunction

  // pin synchronisers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      csMeta_q <= 2'h3;
      sclkMeta_q <= 2'h0;
      dinMeta_q <= 2'h0;
      sclkPrev_q <= 1'b0;
    end else begin
      csMeta_q <= {csMeta_q[0], chipSelectActiveLow};
      sclkMeta_q <= {sclkMeta_q[0], serialClock};
      dinMeta_q <= {dinMeta_q[0], serialDataIn};
      sclkPrev_q <= sclkMeta_q[1];
    end
  end

  assign csLowSync = ~csMeta_q[1];
  assign dinSync = dinMeta_q[1];
  // idle-low clock, host samples on the rising edge
  assign sclkRise = sclkMeta_q[1] & ~sclkPrev_q;

  // the byte as it stands once the eighth bit arrives
  assign newByte = ctrl_byte_t'({rxShift_q, dinSync});

  // the next result is taken at the strobe edge
  assign popResult = (state_q == SEQ_WAIT) && sclkRise && csLowSync
    && (edgeCnt_q + 5'h01 == STROBE_EDGE);

  // result buffer between the sar core and the shifter
  result_fifo #(
    .WIDTH(RESULT_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .refClk(ref_clk),
    .nrst(nrst),
    .inValid(resultValid),
    .inData(resultData),
    .inReady(resultReady),
    .outValid(fifoValid),
    .outData(fifoData),
    .outReady(popResult)
  );

  // serial sequencer: start bit, control byte, strobe, result bits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= SEQ_IDLE;
      bitCnt_q <= 3'h0;
      rxShift_q <= '0;
      edgeCnt_q <= 5'h00;
    end else if (!csLowSync) begin
      // select high ends any transfer
      state_q <= SEQ_IDLE;
      bitCnt_q <= 3'h0;
      edgeCnt_q <= 5'h00;
    end else if (sclkRise) begin
      case (state_q)
        SEQ_IDLE: begin
          if (dinSync) begin
            state_q <= SEQ_RECEIVE;
            bitCnt_q <= 3'h0;
            // start bit enters at the bottom so the byte lines up after six shifts plus the bit on the pin
            rxShift_q <= {{(CTRL_BITS-2){1'b0}}, 1'b1};
          end
        end
        SEQ_RECEIVE: begin
          rxShift_q <= {rxShift_q[CTRL_BITS-3:0], dinSync};
          bitCnt_q <= bitCnt_q + 3'h1;
          if (bitCnt_q == 3'(CTRL_BITS - 2)) begin
            state_q <= SEQ_WAIT;
            edgeCnt_q <= 5'h00;
          end
        end
        SEQ_WAIT: begin
          edgeCnt_q <= edgeCnt_q + 5'h01;
          if (edgeCnt_q + 5'h01 == STROBE_EDGE) begin
            state_q <= SEQ_SHIFT;
          end
        end
        SEQ_SHIFT: begin
          edgeCnt_q <= edgeCnt_q + 5'h01;
          if (edgeCnt_q + 5'h01 == LAST_SHIFT_EDGE) begin
            state_q <= SEQ_IDLE;
          end
        end
        default: state_q <= SEQ_IDLE;
      endcase
    end
  end

  // control byte and mode register, loaded only from a complete byte
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      controlByte <= '0;
      powerModeSetting <= PM_RESET;
    end else if (csLowSync && sclkRise && state_q == SEQ_RECEIVE
        && bitCnt_q == 3'(CTRL_BITS - 2)) begin
      controlByte <= newByte;
      powerModeSetting <= {newByte.powerModeBitHigh, newByte.powerModeBitLow};
    end
  end

  // conversion activity: set when the byte completes, cleared after the last bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conversionActive <= 1'b0;
    end else if (!csLowSync) begin
      // an aborted conversion ends with the select
      conversionActive <= 1'b0;
    end else if (sclkRise) begin
      if (state_q == SEQ_RECEIVE && bitCnt_q == 3'(CTRL_BITS - 2)) begin
        conversionActive <= 1'b1;
      end else if (state_q == SEQ_SHIFT && edgeCnt_q + 5'h01 == LAST_SHIFT_EDGE) begin
        conversionActive <= 1'b0;
      end
    end
  end

  // applied power state; the stored mode takes effect only when idle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      powerState <= PWR_NORMAL;
    end else if (conversionActive) begin
      powerState <= PWR_NORMAL;
    end else begin
      // reduced needs no wait, next byte starts at once
      powerState <= decodeMode(powerModeSetting);
    end
  end

  // strobe: one sclk period, two periods after the last control bit
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      conversionStrobeOut <= 1'b0;
    end else if (!csLowSync) begin
      conversionStrobeOut <= 1'b0;
    end else if (sclkRise) begin
      conversionStrobeOut <= popResult;
    end
  end

  // data output shifter; zeros pad both ends of the result
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      serialDataOut <= 1'b0;
      txShift_q <= '0;
    end else if (csLowSync && sclkRise) begin
      if (popResult) begin
        // an empty buffer yields a zero result rather than a stall
        txShift_q <= fifoValid ? fifoData : '0;
        serialDataOut <= 1'b0;
      end else if (state_q == SEQ_SHIFT) begin
        serialDataOut <= txShift_q[RESULT_W-1];
        txShift_q <= {txShift_q[RESULT_W-2:0], 1'b0};
      end else begin
        // trailing and idle bits are zero
        serialDataOut <= 1'b0;
      end
    end
  end

  // output enables follow the synchronised select
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      serialDataOutOe <= 1'b0;
      conversionStrobeOutOe <= 1'b0;
    end else begin
      serialDataOutOe <= csLowSync;
      conversionStrobeOutOe <= csLowSync;
    end
  end

  // ready flag after the initialisation time; informational, not a gate
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      readyCnt_q <= '0;
      readyToConvert <= 1'b0;
    end else if (!readyToConvert) begin
      readyCnt_q <= readyCnt_q + 1'b1;
      readyToConvert <= (readyCnt_q == READY_W'(READY_CYCLES - 1));
    end
  end

endmodule // adc_power_mode_serial_control

//--- verilog/result_fifo.sv
// small synchronous fifo of converter results, flip-flop storage
// assumes both sides on ref_clk; writer honours inReady, reader honours outValid
module result_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic refClk,
  input wire logic nrst,
  // filling side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // draining side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  // full level needs one bit more than the pointers, or a power-of-two depth reads as zero
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];  // storage words
  logic [AW-1:0] wrPtr_q;  // next slot to write
  logic [AW-1:0] rdPtr_q;  // next slot to read
  logic [AW:0] count_q;  // words held
  logic doWrite;
  logic doRead;

  assign doWrite = inValid & inReady;
  assign doRead = outValid & outReady;
  assign outValid = (count_q != '0);
  assign outData = mem[rdPtr_q];

  // storage write
  always_ff @(posedge refClk) begin
    if (doWrite) begin
      mem[wrPtr_q] <= inData;
    end
  end

  // pointers wrap at depth
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
    end else begin
      if (doWrite) begin
        wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
      end
      if (doRead) begin
        rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
      end
    end
  end

  // fill level and registered ready, so a full fifo stalls the source
  always_ff @(posedge refClk or negedge nrst) begin
    if (!nrst) begin
      count_q <= '0;
      inReady <= 1'b1;
    end else begin
      case ({doWrite, doRead})
        2'b10: begin
          count_q <= count_q + 1'b1;
          inReady <= (count_q + 1'b1) != DEPTH_C;
        end
        2'b01: begin
          count_q <= count_q - 1'b1;
          inReady <= 1'b1;
        end
        default: begin
          count_q <= count_q;
          inReady <= count_q != DEPTH_C;
        end
      endcase
    end
  end

endmodule // result_fifo
